/* File: sep_defs.vh */
// constants for the serial eeprom bus target
`ifndef SEP_DEFS_VH
`define SEP_DEFS_VH
`define SEP_TYPE_CODE    4'ha
`define SEP_ADDR_W       10
`define SEP_BYTE_BITS    4'h8
`define SEP_ACK_SLOT     4'h9
`define SEP_PAGE_BYTES   16
`define SEP_FIFO_DEPTH   16
`define SEP_FIFO_AW      4
`define SEP_FIFO_W       12
`define SEP_SCL_MAX_KHZ  400
`define SEP_CLK_MHZ      100
`define SEP_PROG_MS      5
// 5 ms at 100 MHz, sized to the program timer so the parameter takes it whole
`define SEP_PROG_CYCLES  20'd500000
`define SEP_TMR_W        20
`endif

/* File: sep_eeprom_target.v */
// two-wire eeprom target: page fifo and bus target logic
`timescale 1ns/1ps
`include "sep_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// small fifo between the byte receiver and the page latch
module sep_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] store_r [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_r;
    reg [AW-1:0]    rdPtr_r;
    reg [AW:0]      count_r;
    wire            doPush;
    wire            doPop;

    // full and empty come straight from the occupancy count
    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData  = store_r[rdPtr_r];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    // pointers and count
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (doPush)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (doPop)
                rdPtr_r <= rdPtr_r + 1'b1;
            if (doPush & ~doPop)
                count_r <= count_r + 1'b1;
            else if (doPop & ~doPush)
                count_r <= count_r - 1'b1;
        end
    end

    // storage needs no reset, the count guards it
    always @(posedge clk) begin
        if (doPush)
            store_r[wrPtr_r] <= inData;
    end
endmodule // sep_fifo

////////////////////////////////////////////////////////////////////////////////
// bus target: start/stop detect, address match, ack, page write, reads
module sep_eeprom_target #(
    parameter [`SEP_TMR_W-1:0] PROG_CYCLES = `SEP_PROG_CYCLES
) (
    input  wire clk,
    input  wire rst,
    input  wire sclPin,
    input  wire sdaIn,
    input  wire chipSelectPin,
    input  wire writeInhibitPin,
    output wire sdaOut,
    output wire sdaOe,
    output wire progBusy,
    output wire standby
);
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_DEV   = 6'h02;
    localparam [5:0] ST_MADDR = 6'h04;
    localparam [5:0] ST_WDATA = 6'h08;
    localparam [5:0] ST_RDATA = 6'h10;
    localparam [5:0] ST_HOLD  = 6'h20;

    // synchronisers: stage 1 is read only by stage 2
    reg        sclS1_r, sclS2_r, sclS3_r;
    reg        sdaS1_r, sdaS2_r, sdaS3_r;
    reg        csS1_r, csS2_r;
    reg        wpS1_r, wpS2_r;

    reg [5:0]  state_r;
    reg [5:0]  nxtState_r;
    reg [3:0]  bitCnt_r;
    reg [7:0]  shift_r;
    reg [7:0]  txByte_r;
    reg        sdaOe_r;
    reg        sdaOut_r;
    reg        standby_r;
    reg [1:0]  upper_r;
    reg [5:0]  pageBase_r;
    reg [3:0]  off_r;
    reg [9:0]  addrCnt_r;
    reg        wrote_r;
    reg        mAck_r;
    reg        pushValid_r;
    reg [11:0] pushData_r;
    reg        clearPage_r;

    reg                  progBusy_r;
    reg                  committed_r;
    reg [`SEP_TMR_W-1:0] tmr_r;

    reg [7:0]  mem_r [0:(1<<`SEP_ADDR_W)-1];
    reg [7:0]  pageData_r [0:`SEP_PAGE_BYTES-1];
    reg [15:0] pageMask_r;

    wire        sclRise, sclFall, startSeen, stopSeen;
    wire        fifoInReady, fifoOutValid, fifoOutReady;
    wire [11:0] fifoOutData;
    wire        commitNow;
    wire [7:0]  rdByte;

    // type code and chip-select compare of the address word
    function devMatch;
        input [7:0] word;
        input       cs;
        begin
            devMatch = (word[7:4] == `SEP_TYPE_CODE) && (word[3] == cs);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; open pins are pulled low outside, so select and inhibit reset to 0, clock and data to 1
    always @(posedge clk) begin
        if (rst) begin
            sclS1_r <= 1'b1;
            sclS2_r <= 1'b1;
            sclS3_r <= 1'b1;
            sdaS1_r <= 1'b1;
            sdaS2_r <= 1'b1;
            sdaS3_r <= 1'b1;
            csS1_r  <= 1'b0;
            csS2_r  <= 1'b0;
            wpS1_r  <= 1'b0;
            wpS2_r  <= 1'b0;
        end else begin
            sclS1_r <= sclPin;
            sclS2_r <= sclS1_r;
            sclS3_r <= sclS2_r;
            sdaS1_r <= sdaIn;
            sdaS2_r <= sdaS1_r;
            sdaS3_r <= sdaS2_r;
            csS1_r  <= chipSelectPin;
            csS2_r  <= csS1_r;
            wpS1_r  <= writeInhibitPin;
            wpS2_r  <= wpS1_r;
        end
    end

    // edges and bus conditions, all from second stage onward
    assign sclRise   = sclS2_r & ~sclS3_r;
    assign sclFall   = ~sclS2_r & sclS3_r;
    assign startSeen = sclS2_r & sclS3_r & sdaS3_r & ~sdaS2_r;
    assign stopSeen  = sclS2_r & sclS3_r & ~sdaS3_r & sdaS2_r;
    assign rdByte    = mem_r[addrCnt_r];

    ////////////////////////////////////////////////////////////////////////////
    // bus state machine; our own drive only moves after a clock fall,
    // so it can never look like a start or stop to us
    always @(posedge clk) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            nxtState_r  <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            txByte_r    <= 8'h00;
            sdaOe_r     <= 1'b0;
            sdaOut_r    <= 1'b0;
            upper_r     <= 2'h0;
            pageBase_r  <= 6'h00;
            off_r       <= 4'h0;
            addrCnt_r   <= 10'h000;
            wrote_r     <= 1'b0;
            mAck_r      <= 1'b0;
            pushValid_r <= 1'b0;
            pushData_r  <= 12'h000;
            clearPage_r <= 1'b0;
        end else begin
            pushValid_r <= 1'b0;
            clearPage_r <= 1'b0;
            if (startSeen) begin
                state_r  <= ST_DEV;
                bitCnt_r <= 4'h0;
                sdaOe_r  <= 1'b0;
                wrote_r  <= 1'b0;
            end else if (stopSeen) begin
                state_r <= ST_IDLE;
                sdaOe_r <= 1'b0;
            end else begin
                case (state_r)
                ST_DEV, ST_MADDR, ST_WDATA: begin
                    if (sclRise && bitCnt_r < `SEP_BYTE_BITS) begin
                        shift_r  <= {shift_r[6:0], sdaS2_r};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == `SEP_BYTE_BITS) begin
                        bitCnt_r <= `SEP_ACK_SLOT;
                        if (state_r == ST_DEV) begin
                            if (!devMatch(shift_r, csS2_r)) begin
                                state_r <= ST_IDLE;
                            end else if (!shift_r[0] && progBusy_r) begin
                                state_r <= ST_IDLE;
                            end else begin
                                sdaOe_r <= 1'b1;
                                upper_r <= shift_r[2:1];
                                nxtState_r <= shift_r[0] ? ST_RDATA : ST_MADDR;
                            end
                        end else if (state_r == ST_MADDR) begin
                            sdaOe_r     <= 1'b1;
                            addrCnt_r   <= {upper_r, shift_r};
                            pageBase_r  <= {upper_r, shift_r[7:4]};
                            off_r       <= shift_r[3:0];
                            clearPage_r <= 1'b1;
                            nxtState_r  <= ST_WDATA;
                        end else if (!wpS2_r && fifoInReady) begin
                            sdaOe_r     <= 1'b1;
                            pushValid_r <= 1'b1;
                            pushData_r  <= {off_r, shift_r};
                            off_r       <= off_r + 4'h1;
                            addrCnt_r   <= {pageBase_r, off_r + 4'h1};
                            wrote_r     <= 1'b1;
                            nxtState_r  <= ST_WDATA;
                        end else begin
                            nxtState_r <= ST_HOLD;
                        end
                    end else if (sclFall && bitCnt_r == `SEP_ACK_SLOT) begin
                        bitCnt_r <= 4'h0;
                        state_r  <= nxtState_r;
                        if (nxtState_r == ST_RDATA) begin
                            txByte_r  <= rdByte;
                            addrCnt_r <= addrCnt_r + 10'h001;
                            sdaOe_r   <= ~rdByte[7];
                        end else begin
                            sdaOe_r <= 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise && bitCnt_r < `SEP_BYTE_BITS) begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r < `SEP_BYTE_BITS) begin
                        sdaOe_r <= ~txByte_r[3'h7 - bitCnt_r[2:0]];
                    end else if (sclFall && bitCnt_r == `SEP_BYTE_BITS) begin
                        sdaOe_r <= 1'b0;
                    end else if (sclRise && bitCnt_r == `SEP_BYTE_BITS) begin
                        mAck_r   <= ~sdaS2_r;
                        bitCnt_r <= `SEP_ACK_SLOT;
                    end else if (sclFall && bitCnt_r == `SEP_ACK_SLOT) begin
                        bitCnt_r <= 4'h0;
                        if (mAck_r) begin
                            txByte_r  <= rdByte;
                            addrCnt_r <= addrCnt_r + 10'h001;
                            sdaOe_r   <= ~rdByte[7];
                        end else begin
                            state_r <= ST_HOLD;
                        end
                    end
                end
                ST_IDLE, ST_HOLD: begin
                    sdaOe_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_IDLE;
                    sdaOe_r <= 1'b0;
                end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program cycle: starts on the stop that ends a write with data
    assign commitNow = progBusy_r & ~committed_r & ~fifoOutValid & ~pushValid_r;

    always @(posedge clk) begin
        if (rst) begin
            progBusy_r  <= 1'b0;
            committed_r <= 1'b0;
            tmr_r       <= {`SEP_TMR_W{1'b0}};
            standby_r   <= 1'b1;
        end else begin
            standby_r <= (state_r == ST_IDLE) & ~progBusy_r;
            if (!progBusy_r) begin
                if (stopSeen && wrote_r && state_r == ST_WDATA) begin
                    progBusy_r  <= 1'b1;
                    committed_r <= 1'b0;
                    tmr_r       <= {`SEP_TMR_W{1'b0}};
                end
            end else begin
                if (commitNow)
                    committed_r <= 1'b1;
                if (tmr_r == PROG_CYCLES - 1'b1)
                    progBusy_r <= 1'b0;
                else
                    tmr_r <= tmr_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write bytes queue here; drain stops only while the page is committed
    assign fifoOutReady = ~commitNow;

    sep_fifo #(
        .WIDTH (`SEP_FIFO_W),
        .DEPTH (`SEP_FIFO_DEPTH),
        .AW    (`SEP_FIFO_AW)
    ) uFifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (pushValid_r),
        .inReady  (fifoInReady),
        .inData   (pushData_r),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // page latch: one slot per low address, later bytes overwrite
    genvar g;
    generate
        for (g = 0; g < `SEP_PAGE_BYTES; g = g + 1) begin : gPage
            always @(posedge clk) begin
                if (rst) begin
                    pageData_r[g] <= 8'hff;
                    pageMask_r[g] <= 1'b0;
                end else if (clearPage_r || commitNow) begin
                    pageMask_r[g] <= 1'b0;
                end else if (fifoOutValid && fifoOutData[11:8] == g) begin
                    pageData_r[g] <= fifoOutData[7:0];
                    pageMask_r[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // latched bytes of the page (mask set) go to the array in one cycle; the array has no reset
    integer i;
    always @(posedge clk) begin
        if (commitNow) begin
            for (i = 0; i < `SEP_PAGE_BYTES; i = i + 1) begin
                if (pageMask_r[i])
                    mem_r[{pageBase_r, i[3:0]}] <= pageData_r[i];
            end
        end
    end

    assign sdaOut   = sdaOut_r;
    assign sdaOe    = sdaOe_r;
    assign progBusy = progBusy_r;
    assign standby  = standby_r;
endmodule // sep_eeprom_target

/* File: sep_eeprom_target_props.sv */
// port assertions for the eeprom bus target
`timescale 1ns/1ps
module sep_eeprom_target_props #(
    parameter int PROG_CYCLES = 500000
) (
    input logic clk,
    input logic rst,
    input logic sclPin,
    input logic sdaIn,
    input logic chipSelectPin,
    input logic writeInhibitPin,
    input logic sdaOut,
    input logic sdaOe,
    input logic progBusy,
    input logic standby
);
    int busyCnt_r;
    int stopAge_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // program-cycle length and age of the last stop seen at the pins
    always @(posedge clk) begin
        if (rst) begin
            busyCnt_r <= 0;
            stopAge_r <= 100;
        end else begin
            busyCnt_r <= progBusy ? busyCnt_r + 1 : 0;
            if (sclPin && $rose(sdaIn))
                stopAge_r <= 0;
            else if (stopAge_r < 100)
                stopAge_r <= stopAge_r + 1; // saturate, only small ages matter
        end
    end
    sequence s_rise; $rose(sclPin); endsequence
    sequence s_keep; $stable(sdaOe) [*5]; endsequence
    property p_rst; disable iff (1'b0) rst |=> standby && !progBusy && !sdaOe; endproperty
    property p_od; sdaOut == 1'b0; endproperty
    property p_chg; $changed(sdaOe) |-> !sclPin; endproperty
    property p_keep; s_rise |-> s_keep; endproperty
    property p_excl; progBusy |-> !standby; endproperty
    property p_launch; $rose(progBusy) |-> stopAge_r <= 6; endproperty
    property p_len; progBusy |-> busyCnt_r < PROG_CYCLES + 3; endproperty
    property p_end; $fell(progBusy) |-> ##[0:2] standby; endproperty
    property p_ack; $rose(sdaOe) |-> !$past(standby, 4); endproperty
    a_rst: assert property (p_rst) else $error("state wrong after reset");
    a_od: assert property (p_od) else $error("data driven high");
    a_chg: assert property (p_chg) else $error("data moved with clock high");
    a_keep: assert property (p_keep) else $error("data moved in high phase");
    a_excl: assert property (p_excl) else $error("standby while programming");
    a_launch: assert property (p_launch) else $error("program without stop");
    a_len: assert property (p_len) else $error("program cycle too long");
    a_end: assert property (p_end) else $error("no standby after program");
    a_ack: assert property (p_ack) else $error("acknowledge from standby");
endmodule // sep_eeprom_target_props

bind sep_eeprom_target sep_eeprom_target_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .clk(clk), .rst(rst), .sclPin(sclPin), .sdaIn(sdaIn), .chipSelectPin(chipSelectPin),
    .writeInhibitPin(writeInhibitPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .progBusy(progBusy), .standby(standby));

/* File: sep_bus_ctrl.sv */
// two-wire controller model: drives the bus clock, releases data to a pull-up
`timescale 1ns/1ps
module sep_bus_ctrl (
    input  wire clk,
    input  wire sdaOe,
    output wire sclPin,
    output wire sdaIn
);
    reg scl_r;
    reg rel_r;
    // open-drain wire; clock stands high between frames
    assign sdaIn  = rel_r & ~sdaOe;
    assign sclPin = scl_r;
    initial begin
        scl_r = 1'b1;
        rel_r = 1'b1;
    end
    // a quarter of the 160 ns bus clock
    task wt;
        repeat (4) @(negedge clk);
    endtask
    // data moves only in the low phase, sampled mid-high
    task xbit(input b, output s);
        scl_r = 1'b0;
        wt;
        rel_r = b;
        wt;
        scl_r = 1'b1;
        wt;
        s = sdaIn;
        wt;
    endtask
    // eight bits msb first, then the acknowledge slot
    task xbyte(input [7:0] d, input m, output [7:0] q, output a);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            xbit(d[i], q[i]);
        xbit(m, a);
    endtask
    // data edge in the high phase: start when falling, stop when rising
    task cond(input r0, input r1);
        scl_r = 1'b0;
        wt;
        rel_r = r0;
        wt;
        scl_r = 1'b1;
        wt;
        rel_r = r1;
        wt;
    endtask
endmodule // sep_bus_ctrl

/* File: tb_sep_eeprom_target.sv */
// self-checking bench for the eeprom bus target
`timescale 1ns/1ps
module tb_sep_eeprom_target;
    reg         clk;
    reg         rst;
    reg         chipSelectPin;
    reg         writeInhibitPin;
    wire        sclPin, sdaIn, sdaOut, sdaOe, progBusy, standby;
    integer     failures, checks, cntM, i, k, b, r;
    integer     memM [0:1023];
    logic [7:0] q;
    logic       a;
    sep_eeprom_target #(.PROG_CYCLES(20'd200)) dut (
        .clk(clk), .rst(rst), .sclPin(sclPin), .sdaIn(sdaIn),
        .chipSelectPin(chipSelectPin), .writeInhibitPin(writeInhibitPin),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .progBusy(progBusy), .standby(standby));
    sep_bus_ctrl ctrl (.clk(clk), .sdaOe(sdaOe), .sclPin(sclPin), .sdaIn(sdaIn));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // verdict and end of run
    task complete_run;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    function [7:0] aw(input [9:0] ad, input rw);
        aw = {4'ha, chipSelectPin, ad[9:8], rw};
    endfunction
    // start, address word, acknowledge expected or not
    task sendAddr(input [7:0] w, input ack);
        ctrl.cond(1'b1, 1'b0);
        ctrl.xbyte(w, 1'b1, q, a);
        chk1(a, ~ack);
    endtask
    // bounded wait for the end of the program cycle
    task waitIdle;
        integer n;
        for (n = 0; n < 400 && standby !== 1'b1; n = n + 1)
            @(negedge clk);
        chk1(standby, 1'b1);
    endtask
    // page write of n random bytes; the model wraps in the low four bits
    task pageWr(input [9:0] ad, input integer n, input wp);
        sendAddr(aw(ad, 1'b0), 1'b1);
        ctrl.xbyte(ad[7:0], 1'b1, q, a);
        chk1(a, 1'b0);
        for (i = 0; i < n; i = i + 1) begin
            b = $urandom_range(255);
            ctrl.xbyte(b[7:0], 1'b1, q, a);
            chk1(a, wp);
            if (!wp)
                memM[{ad[9:4], ad[3:0] + i[3:0]}] = b;
        end
        if (!wp)
            cntM = {ad[9:4], ad[3:0] + n[3:0]};
        ctrl.cond(1'b0, 1'b1);
        repeat (2) @(negedge clk);
        chk1(progBusy, ~wp);
        if (!wp) begin
            sendAddr(aw(ad, 1'b0), 1'b0);
            ctrl.cond(1'b0, 1'b1);
            waitIdle;
            sendAddr(aw(ad, 1'b0), 1'b1);
            ctrl.cond(1'b0, 1'b1);
        end
    endtask
    // optional dummy write, then sequential read and one unacked byte
    task seqRd(input [9:0] ad, input integer n, input dummy);
        integer j;
        if (dummy) begin
            sendAddr(aw(ad, 1'b0), 1'b1);
            ctrl.xbyte(ad[7:0], 1'b1, q, a);
            chk1(a, 1'b0);
            cntM = ad;
        end
        sendAddr(aw(cntM[9:0], 1'b1), 1'b1);
        for (j = 0; j < n; j = j + 1) begin
            ctrl.xbyte(8'hff, j == n - 1, q, a);
            chk(q, memM[cntM][7:0]);
            cntM = (cntM + 1) % 1024;
        end
        ctrl.xbyte(8'hff, 1'b1, q, a);
        chk(q, 8'hff);
        ctrl.cond(1'b0, 1'b1);
        repeat (4) @(negedge clk);
        chk1(standby, 1'b1);
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        failures = failures + 1;
        complete_run;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        chipSelectPin = 1'b0;
        writeInhibitPin = 1'b0;
        failures = 0;
        checks = 0;
        void'($urandom(67858));
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk({5'h0, standby, progBusy, sdaOe}, 8'h04);
        repeat (4) @(negedge clk);
        for (k = 0; k < 2; k = k + 1) begin
            chipSelectPin = k[0];
            sendAddr(aw(10'h0, 1'b0) ^ 8'h08, 1'b0);
            sendAddr(aw(10'h0, 1'b1) ^ 8'h80, 1'b0);
            repeat (4) @(negedge clk);
            chk1(standby, 1'b1);
            ctrl.cond(1'b0, 1'b1);
            pageWr(k ? 10'h005 : 10'h3f3, k ? 16 : 18, 1'b0);
            seqRd(10'h0, 2, 1'b0);
        end
        seqRd(10'h3fd, 6, 1'b1);
        writeInhibitPin = 1'b1;
        pageWr(10'h3f8, 2, 1'b1);
        seqRd(10'h3f8, 2, 1'b1);
        writeInhibitPin = 1'b0;
        for (k = 0; k < 3; k = k + 1) begin
            r = $urandom_range(1023);
            pageWr(r[9:0], $urandom_range(16, 1), 1'b0);
            seqRd(r[9:0], 1, 1'b1);
        end
        complete_run;
    end
endmodule // tb_sep_eeprom_target
